// ### rtl/fmc_pkg.sv
// Constants and types shared by the flash mode control block
package fmc_pkg;

	// Register byte addresses on the internal bus
	localparam logic [31:0] FMC_ADDR_LOWER = 32'hffff8580;
	localparam logic [31:0] FMC_ADDR_UPPER = 32'hffff8581;

	// Access size code for a byte access
	localparam logic [1:0] FMC_SIZE_BYTE = 2'h0;

	// Bus cycles per register access, request cycle included
	localparam int FMC_ACCESS_CYCLES = 3;

	// Lower control register field positions
	localparam int FMC_HW_EN_BIT = 7;
	localparam int FMC_SW_EN_BIT = 6;

	// Upper control register field positions
	localparam int FMC_ERR_BIT = 7;
	localparam int FMC_RSVD_BIT = 6;

	// Per-area field positions, same in both registers
	localparam int FMC_ESU_BIT = 5;
	localparam int FMC_PSU_BIT = 4;
	localparam int FMC_EV_BIT = 3;
	localparam int FMC_PV_BIT = 2;
	localparam int FMC_E_BIT = 1;
	localparam int FMC_P_BIT = 0;
	localparam int FMC_AREA_BITS = 6;

	// Reset and disabled read values
	localparam logic [7:0] FMC_RESET_VAL = 8'h00;
	localparam logic [7:0] FMC_LOWER_OFF_READ = 8'h80;
	localparam logic [7:0] FMC_UPPER_OFF_READ = 8'h00;

	// Array address split between the two areas
	localparam int FMC_FADDR_W = 18;
	localparam logic [17:0] FMC_UPPER_BASE = 18'h20000;
	localparam logic [17:0] FMC_UPPER_TOP = 18'h3ffff;

	// Bus access sequencer, Gray coded along idle, wait, done
	typedef enum logic [1:0] {
		FMC_ST_IDLE = 2'h0,
		FMC_ST_WAIT = 2'h1,
		FMC_ST_DONE = 2'h3
	} fmc_state_e;

endpackage

// ### rtl/fmc_sync2.sv
// Two flip-flop level synchroniser for a pin input
`timescale 1ns/1ns
module fmc_sync2 #(
	parameter logic RESET_VAL = 1'b1
) (
	input wire logic ref_clk_in,
	input wire logic nrst_in,
	input wire logic clk_en_in,
	input wire logic async_in,
	output logic sync_out
);
	logic meta_q; // First stage, read only by the second stage
	logic sync_q; // Second stage, safe to use

	// Reset to the protected level so nothing unlocks early
	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			meta_q <= RESET_VAL;
			sync_q <= RESET_VAL;
		end else if (clk_en_in) begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;
endmodule // fmc_sync2

// ### rtl/fmc_area_ctrl.sv
// Six mode bits of one flash area with their write gating
`timescale 1ns/1ns
module fmc_area_ctrl #(
	parameter int NBITS = fmc_pkg::FMC_AREA_BITS
) (
	input wire logic ref_clk_in,
	input wire logic nrst_in,
	input wire logic clk_en_in,
	input wire logic clear_in,
	input wire logic wr_in,
	input wire logic [NBITS-1:0] wdata_in,
	input wire logic hw_en_in,
	input wire logic sw_en_in,
	output logic [NBITS-1:0] ctrl_out
);
	logic [NBITS-1:0] ctrl_q; // Mode bits
	logic [NBITS-1:0] ctrl_d; // Next mode bits
	logic [NBITS-1:0] allow; // Per-bit write permission
	logic base_ok; // Hardware and software enables both high

	// Go bits also need their own setup bit already set
	function automatic logic bit_allowed(input int idx,
		input logic base, input logic esu, input logic psu);
		logic ok;
		ok = base;
		if (idx == fmc_pkg::FMC_E_BIT) begin
			ok = base & esu;
		end
		if (idx == fmc_pkg::FMC_P_BIT) begin
			ok = base & psu;
		end
		return ok;
	endfunction

	assign base_ok = hw_en_in & sw_en_in;

	// Same gating pattern repeats for every bit
	genvar i;
	generate
		for (i = 0; i < NBITS; i++) begin : g_bit
			// Setup and verify bits need both enables; go bits also setup
			assign allow[i] = bit_allowed(i, // [RULE_06] [RULE_17]
				base_ok, // [RULE_07] [RULE_08]
				ctrl_q[fmc_pkg::FMC_ESU_BIT], // [RULE_18]
				ctrl_q[fmc_pkg::FMC_PSU_BIT]); // [RULE_19]
			// Clear dominates; otherwise a permitted write loads the bit
			assign ctrl_d[i] = clear_in ? 1'b0 :
				((wr_in & allow[i]) ? wdata_in[i] : ctrl_q[i]);
		end
	endgenerate

	// Mode bit storage
	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			ctrl_q <= '0;
		end else if (clk_en_in) begin
			ctrl_q <= ctrl_d;
		end
	end

	assign ctrl_out = ctrl_q;
endmodule // fmc_area_ctrl

// ### rtl/fmc_ctrl.sv
// Flash mode control registers for the lower and upper flash areas
//
// Operation
// [RULE_01] Lower verify modes follow software enable set
// [RULE_02] Lower program: enable, program setup, program
// [RULE_03] Lower erase: enable, erase setup, erase
// [RULE_04] Lower register resets; reads 0x80 if unprotected
// [RULE_05] Flash disabled: lower reads 0x80, writes ignored
// [RULE_06] Enable, setup, verify writes need both enables; the enable write itself checks only the hardware enable
// [RULE_07] Lower erase write also needs erase setup
// [RULE_08] Lower program write also needs program setup
// [RULE_09] Bit 7 mirrors write-protect pin, inverted
// [RULE_10] Software sets enable before other bits
// [RULE_11] One lower mode bit, never with enable
// [RULE_12] Upper verify modes follow software enable set
// [RULE_13] Upper program: enable, program setup, program
// [RULE_14] Upper erase: enable, erase setup, erase
// [RULE_15] Upper register clears; error flag only at reset
// [RULE_16] Flash disabled: upper reads 0x00, writes ignored
// [RULE_17] Upper setup, verify writes need both enables
// [RULE_18] Upper erase write also needs erase setup
// [RULE_19] Upper program write also needs program setup
// [RULE_20] Error flag sets on failure, blocks program/erase
// [RULE_21] Upper bit 6 always reads zero
// [RULE_22] Software sets one upper mode bit only
// [RULE_23] Byte access only, consecutive addresses, three cycles
// [RULE_24] Area bits act only on their addresses
`timescale 1ns/1ns
module fmc_ctrl (
	input wire logic ref_clk_in,
	input wire logic nrst_in,
	input wire logic clk_en_in,
	input wire logic write_protect_pin_n_in,
	input wire logic flash_disabled_in,
	input wire logic standby_in,
	input wire logic op_fail_in,
	input wire logic [fmc_pkg::FMC_FADDR_W-1:0] flash_addr_in,
	input wire logic bus_req_in,
	input wire logic bus_wr_in,
	input wire logic [1:0] bus_size_in,
	input wire logic [31:0] bus_addr_in,
	input wire logic [7:0] bus_wdata_in,
	output logic [7:0] bus_rdata_out,
	output logic bus_ack_out,
	output logic hw_write_enable_status_out,
	output logic sw_write_enable_out,
	output logic flash_error_flag_out,
	output logic erase_setup_out,
	output logic program_setup_out,
	output logic erase_verify_out,
	output logic program_verify_out,
	output logic erase_go_out,
	output logic program_go_out
);
	localparam int NB = fmc_pkg::FMC_AREA_BITS;

	// Synchronised write-protect pin, high means protected
	logic pin_sync;
	// Hardware enable derived from the pin level
	logic hw_en;

	// Bus sequencer state and latched request
	fmc_pkg::fmc_state_e st_q;
	fmc_pkg::fmc_state_e st_d;
	logic [31:0] addr_q;
	logic [7:0] wdata_q;
	logic wr_q;
	logic byte_q;

	// Register state owned by this module
	logic swe_q;
	logic swe_d;
	logic err_q;
	logic err_d;
	logic hw_q;

	// Per-area mode bits from the area blocks
	logic [NB-1:0] lower_bits;
	logic [NB-1:0] upper_bits;

	// Decoded access at the completing cycle
	logic done;
	logic hit_lower;
	logic hit_upper;
	logic wr_lower;
	logic wr_upper;
	logic take;

	// Clears for the two areas and the enable
	logic clear_sw;
	logic clear_area;

	// Read data and answer registers
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic [7:0] lower_view;
	logic [7:0] upper_view;
	logic ack_q;

	// Array-side mode outputs
	logic in_upper;
	logic in_range;
	logic [NB-1:0] sel_bits;
	logic op_block;
	logic [NB-1:0] mode_q;
	logic [NB-1:0] mode_d;

	// Pin crosses in through two flops; reset value means protected
	fmc_sync2 #(
		.RESET_VAL(1'b1)
	) u_pin_sync (
		.ref_clk_in(ref_clk_in),
		.nrst_in(nrst_in),
		.clk_en_in(clk_en_in),
		.async_in(write_protect_pin_n_in),
		.sync_out(pin_sync)
	);

	// Low pin level means programming hardware is enabled
	assign hw_en = ~pin_sync; // [RULE_09]

	// Bus decode
	// A request is taken only while idle and not answering, so accesses
	// never overlap and a master may hold its request through the ack edge
	assign take = (st_q == fmc_pkg::FMC_ST_IDLE) & bus_req_in & ~ack_q;
	assign done = (st_q == fmc_pkg::FMC_ST_DONE);
	// Only byte accesses reach the registers
	assign hit_lower = byte_q &
		(addr_q == fmc_pkg::FMC_ADDR_LOWER); // [RULE_23]
	assign hit_upper = byte_q &
		(addr_q == fmc_pkg::FMC_ADDR_UPPER); // [RULE_23]
	// Writes are dropped while the flash is disabled
	assign wr_lower = done & wr_q & hit_lower &
		~flash_disabled_in; // [RULE_05]
	assign wr_upper = done & wr_q & hit_upper &
		~flash_disabled_in; // [RULE_16]

	// Three-cycle access: take, wait, complete
	always_comb begin
		st_d = st_q;
		case (st_q)
			fmc_pkg::FMC_ST_IDLE: begin
				// Request taken, start the access
				if (take) begin
					st_d = fmc_pkg::FMC_ST_WAIT;
				end
			end
			fmc_pkg::FMC_ST_WAIT: begin
				st_d = fmc_pkg::FMC_ST_DONE; // [RULE_23]
			end
			fmc_pkg::FMC_ST_DONE: begin
				st_d = fmc_pkg::FMC_ST_IDLE;
			end
			default: begin
				// Recover from an illegal code
				st_d = fmc_pkg::FMC_ST_IDLE;
			end
		endcase
	end

	// Sequencer state and request capture
	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			st_q <= fmc_pkg::FMC_ST_IDLE;
			addr_q <= '0;
			wdata_q <= '0;
			wr_q <= 1'b0;
			byte_q <= 1'b0;
		end else if (clk_en_in) begin
			st_q <= st_d;
			// Hold the request so the bus may change meanwhile
			if (take) begin
				addr_q <= bus_addr_in;
				wdata_q <= bus_wdata_in;
				wr_q <= bus_wr_in;
				byte_q <= (bus_size_in == fmc_pkg::FMC_SIZE_BYTE);
			end
		end
	end

	// Standby or protect pin wipes the enable
	assign clear_sw = standby_in | ~hw_en; // [RULE_04]
	// Mode bits also drop whenever the software enable is clear
	assign clear_area = clear_sw | ~swe_q; // [RULE_15]

	// Enable may only be set while the hardware enable is high
	assign swe_d = clear_sw ? 1'b0 :
		(wr_lower ? wdata_q[fmc_pkg::FMC_SW_EN_BIT] : swe_q); // [RULE_06]

	// Failures latch; only reset clears, so a set is never lost
	assign err_d = err_q | op_fail_in; // [RULE_20] [RULE_15]

	// Enable, error flag and hardware status registers
	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			swe_q <= 1'b0;
			err_q <= 1'b0;
			hw_q <= 1'b0;
		end else if (clk_en_in) begin
			swe_q <= swe_d;
			err_q <= err_d;
			hw_q <= hw_en; // [RULE_09]
		end
	end

	// Lower area mode bits; gating uses the enable already stored,
	// so bits written together with the enable are ignored
	fmc_area_ctrl #(
		.NBITS(NB)
	) u_lower (
		.ref_clk_in(ref_clk_in),
		.nrst_in(nrst_in),
		.clk_en_in(clk_en_in),
		.clear_in(clear_area),
		.wr_in(wr_lower),
		.wdata_in(wdata_q[NB-1:0]),
		.hw_en_in(hw_en),
		.sw_en_in(swe_q),
		.ctrl_out(lower_bits)
	); // [RULE_01] [RULE_02] [RULE_03]

	// Upper area mode bits, enabled by the lower register's enable
	fmc_area_ctrl #(
		.NBITS(NB)
	) u_upper (
		.ref_clk_in(ref_clk_in),
		.nrst_in(nrst_in),
		.clk_en_in(clk_en_in),
		.clear_in(clear_area),
		.wr_in(wr_upper),
		.wdata_in(wdata_q[NB-1:0]),
		.hw_en_in(hw_en),
		.sw_en_in(swe_q),
		.ctrl_out(upper_bits)
	); // [RULE_12] [RULE_13] [RULE_14]

	// Read views; disabled flash shows fixed values
	assign lower_view = flash_disabled_in ?
		fmc_pkg::FMC_LOWER_OFF_READ :
		{hw_en, swe_q, lower_bits}; // [RULE_05] [RULE_09] [RULE_04]
	// Reserved bit is forced to zero
	assign upper_view = flash_disabled_in ?
		fmc_pkg::FMC_UPPER_OFF_READ :
		{err_q, 1'b0, upper_bits}; // [RULE_16] [RULE_21]

	// Unmapped or non-byte reads answer zero
	assign rdata_d = hit_lower ? lower_view :
		(hit_upper ? upper_view : fmc_pkg::FMC_RESET_VAL);

	// Answer registers, loaded in the completing cycle
	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			rdata_q <= fmc_pkg::FMC_RESET_VAL;
			ack_q <= 1'b0;
		end else if (clk_en_in) begin
			ack_q <= done;
			// Read data is only refreshed on a read so it stays stable
			if (done & ~wr_q) begin
				rdata_q <= rdata_d;
			end
		end
	end

	// Array address decode picks which area's bits apply
	assign in_upper =
		(flash_addr_in >= fmc_pkg::FMC_UPPER_BASE); // [RULE_24]
	assign in_range =
		(flash_addr_in <= fmc_pkg::FMC_UPPER_TOP); // [RULE_24]
	assign sel_bits = ~in_range ? '0 :
		(in_upper ? upper_bits : lower_bits); // [RULE_24]

	// Error protection or disabled flash stops program and erase
	assign op_block = err_q | flash_disabled_in; // [RULE_20]

	// Mode strobes to the array, go bits blocked under protection
	assign mode_d = {sel_bits[fmc_pkg::FMC_ESU_BIT],
		sel_bits[fmc_pkg::FMC_PSU_BIT],
		sel_bits[fmc_pkg::FMC_EV_BIT],
		sel_bits[fmc_pkg::FMC_PV_BIT],
		sel_bits[fmc_pkg::FMC_E_BIT] & ~op_block,
		sel_bits[fmc_pkg::FMC_P_BIT] & ~op_block}; // [RULE_20]

	// Registered mode outputs keep the array free of decode glitches
	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			mode_q <= '0;
		end else if (clk_en_in) begin
			mode_q <= mode_d;
		end
	end

	// Outputs, all taken straight from flops
	assign bus_rdata_out = rdata_q;
	assign bus_ack_out = ack_q;
	assign hw_write_enable_status_out = hw_q;
	assign sw_write_enable_out = swe_q;
	assign flash_error_flag_out = err_q;
	assign erase_setup_out = mode_q[fmc_pkg::FMC_ESU_BIT];
	assign program_setup_out = mode_q[fmc_pkg::FMC_PSU_BIT];
	assign erase_verify_out = mode_q[fmc_pkg::FMC_EV_BIT];
	assign program_verify_out = mode_q[fmc_pkg::FMC_PV_BIT];
	assign erase_go_out = mode_q[fmc_pkg::FMC_E_BIT];
	assign program_go_out = mode_q[fmc_pkg::FMC_P_BIT];
endmodule // fmc_ctrl

// ### verif/fmc_ctrl_sva.sv
// Port assertions for the flash mode control registers
`timescale 1ns/1ns
module fmc_ctrl_sva (
	input wire logic ref_clk_in,
	input wire logic nrst_in,
	input wire logic op_fail_in,
	input wire logic flash_disabled_in,
	input wire logic bus_req_in,
	input wire logic bus_wr_in,
	input wire logic [31:0] bus_addr_in,
	input wire logic [7:0] bus_rdata_out,
	input wire logic bus_ack_out,
	input wire logic hw_write_enable_status_out,
	input wire logic sw_write_enable_out,
	input wire logic flash_error_flag_out,
	input wire logic erase_go_out,
	input wire logic program_go_out
);
	// Single clock domain, so one shared clock and reset
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!nrst_in);

	chk_ack_one_cycle: assert property (
		bus_ack_out |=> !bus_ack_out)
		else $error("ack held over one cycle");
	chk_ack_latency: assert property (
		bus_ack_out |-> $past(bus_req_in, 3))
		else $error("ack without request three cycles back");
	chk_reset_outputs: assert property (
		$rose(nrst_in) |-> !bus_ack_out &&
		!sw_write_enable_out && !flash_error_flag_out &&
		!hw_write_enable_status_out)
		else $error("outputs not cleared by reset");
	chk_err_sticky: assert property (
		flash_error_flag_out |=> flash_error_flag_out)
		else $error("error flag cleared without reset");
	chk_err_sets: assert property (
		op_fail_in |-> ##[1:2] flash_error_flag_out)
		else $error("error flag missed a failure");
	chk_err_blocks_go: assert property (
		$past(flash_error_flag_out) |->
		!erase_go_out && !program_go_out)
		else $error("go output while error flag set");
	chk_off_blocks_go: assert property (
		$past(flash_disabled_in) |->
		!erase_go_out && !program_go_out)
		else $error("go output while flash disabled");
	chk_rsvd_zero: assert property (
		bus_ack_out && !$past(bus_wr_in, 3) &&
		$past(bus_addr_in, 3) == fmc_pkg::FMC_ADDR_UPPER |->
		!bus_rdata_out[6])
		else $error("reserved upper bit read as one");
	chk_swe_needs_hw: assert property (
		$rose(sw_write_enable_out) |->
		hw_write_enable_status_out)
		else $error("software enable set while protected");
endmodule // fmc_ctrl_sva

// ### verif/fmc_ctrl_tb.sv
// Self-checking bench for the flash mode control registers
`timescale 1ns/1ns
module fmc_ctrl_tb;
	logic ref_clk_in, nrst_in, clk_en_in, write_protect_pin_n_in;
	logic flash_disabled_in, standby_in, op_fail_in, bus_req_in, bus_wr_in;
	logic [17:0] flash_addr_in;
	logic [1:0] bus_size_in;
	logic [31:0] bus_addr_in;
	logic [7:0] bus_wdata_in, bus_rdata_out;
	logic bus_ack_out, hw_write_enable_status_out, sw_write_enable_out;
	logic flash_error_flag_out, erase_setup_out, program_setup_out;
	logic erase_verify_out, program_verify_out, erase_go_out, program_go_out;
	int mismatches = 0;
	int checks = 0;
	// Selected area mode bits, laid out like the register's low six bits
	wire [7:0] mode = {2'h0, erase_setup_out, program_setup_out,
		erase_verify_out, program_verify_out, erase_go_out, program_go_out};
	// Status outputs: hardware enable, software enable, error flag
	wire [7:0] flags = {5'h00, hw_write_enable_status_out,
		sw_write_enable_out, flash_error_flag_out};
	localparam logic [31:0] la = fmc_pkg::FMC_ADDR_LOWER;
	localparam logic [31:0] ua = fmc_pkg::FMC_ADDR_UPPER;
	// Rows: upper select, write byte, expected read back
	logic [16:0] rows [19] = '{17'h07fc0, 17'h042c0, 17'h041c0, 17'h060e0,
		17'h062e2, 17'h050d0, 17'h051d1, 17'h048c8, 17'h044c4, 17'h0bf80,
		17'h040c0, 17'h10200, 17'h10100, 17'h16020, 17'h12222, 17'h11010,
		17'h11111, 17'h10808, 17'h10404};

	fmc_ctrl uut (.*);

	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		checks++;
		if (s !== e) begin
			mismatches++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk_in);
		#1;
	endtask

	// Request held through the edge that samples ack high; read data is
	// taken at that same edge and the request released just after it
	task automatic acc(input logic w, input logic [31:0] a,
		input logic [7:0] d, output logic [7:0] q);
		logic got;
		got = 1'b0;
		q = 8'h00;
		bus_req_in = 1'b1;
		bus_wr_in = w;
		bus_addr_in = a;
		bus_wdata_in = d;
		for (int i = 0; i < 8 && !got; i++) begin
			@(posedge ref_clk_in);
			got = (bus_ack_out === 1'b1);
			q = bus_rdata_out;
		end
		chk({7'h00, got}, 8'h01);
		#1;
		bus_req_in = 1'b0;
		cyc(1);
	endtask

	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		logic [7:0] q;
		acc(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [31:0] a, input logic [7:0] e);
		logic [7:0] q;
		acc(1'b0, a, 8'h00, q);
		chk(q, e);
	endtask

	task automatic end_of_test();
		if (mismatches == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		ref_clk_in = 1'b0;
		forever #5 ref_clk_in = ~ref_clk_in;
	end

	// Hang guard, far beyond the few hundred cycles the tests need
	initial begin
		#20000;
		mismatches++;
		end_of_test();
	end

	initial begin
		{nrst_in, write_protect_pin_n_in, flash_disabled_in} = 3'h0;
		{standby_in, op_fail_in, bus_req_in, bus_wr_in} = 4'h0;
		clk_en_in = 1'b1;
		{flash_addr_in, bus_size_in, bus_addr_in, bus_wdata_in} = 60'h0;
		cyc(5);
		nrst_in = 1'b1;
		cyc(3);
		rd(la, 8'h80);
		rd(ua, 8'h00);
		// Table of mode steps, each area selected at its boundary address;
		// the first write sets the enable, and every mode bit written with it is ignored; go bits are written alone and then with their setup bit
		for (int i = 0; i < 19; i++) begin
			flash_addr_in = rows[i][16] ? 18'h20000 : 18'h1ffff;
			wr(rows[i][16] ? ua : la,
				rows[i][15:8]);
			rd(rows[i][16] ?
				ua : la,
				rows[i]
				[7:0]
				);
			chk(mode, {2'h0, rows[i][5:0]});
		end
		chk(flags, 8'h06);
		// Failure latches the flag and blocks the go output only
		wr(ua, 8'h10);
		wr(ua, 8'h11);
		op_fail_in = 1'b1;
		cyc(1);
		op_fail_in = 1'b0;
		rd(ua, 8'h91);
		chk(mode, 8'h10);
		chk(flags, 8'h07);
		wr(la, 8'h00);
		rd(ua, 8'h80);
		// Disabled flash: fixed reads, writes dropped
		flash_disabled_in = 1'b1;
		wr(la, 8'h40);
		rd(la, 8'h80);
		rd(ua, 8'h00);
		flash_disabled_in = 1'b0;
		rd(la, 8'h80);
		// Unmapped address and non-byte size read zero
		rd(32'hffff8582, 8'h00);
		bus_size_in = 2'h2;
		rd(la, 8'h00);
		bus_size_in = 2'h0;
		// Protect pin high drops the enables and refuses new ones
		wr(la, 8'h40);
		write_protect_pin_n_in = 1'b1;
		cyc(4);
		rd(la, 8'h00);
		chk(flags, 8'h01);
		wr(la, 8'h40);
		rd(la, 8'h00);
		// Standby clears the software enable
		write_protect_pin_n_in = 1'b0;
		cyc(4);
		wr(la, 8'h40);
		standby_in = 1'b1;
		rd(la, 8'h80);
		standby_in = 1'b0;
		// Second reset with the pin high also clears the error flag
		op_fail_in = 1'b1;
		write_protect_pin_n_in = 1'b1;
		cyc(1);
		op_fail_in = 1'b0;
		nrst_in = 1'b0;
		cyc(5);
		nrst_in = 1'b1;
		cyc(3);
		rd(la, 8'h00);
		rd(ua, 8'h00);
		chk(flags, 8'h00);
		end_of_test();
	end
endmodule // fmc_ctrl_tb

bind fmc_ctrl fmc_ctrl_sva u_sva (.*);
